// *** hdl/pdpa_core.v ***
// Poll, data request, acknowledgment and pending-data follow-up logic of a low-rate MAC.
// Assumes frame events arrive as one-cycle strobes from filtered receive and transmit paths.
//
// What this block does
// - Beacon lists us, auto request: send request
// - Poll request from above sends data request
// - Request after response wait following acknowledgment
// - Omit destination when addressed to PAN coordinator
// - Poll security for polls, stored otherwise
// - Coordinator acknowledges each data request received while the responder is idle
// - Pending bit from queue, else one
// - Pending bit clear means no data
// - Pending set: receive at most total wait
// - Send queued data, else empty unacknowledged frame
// - Skip backoff only on boundary window with room
// - No resend of follow-up; await new request
// - Timeout or empty payload means no data
// - Acknowledge coordinator data that asks for it
// - Pending bit in data means more queued
// - Beacons, acknowledgments, broadcasts never request acknowledgment
// - No acknowledgment for unrequested; originator assumes success
// - Acknowledgment carries the acknowledged sequence number
// - Outside contention period: acknowledge exactly after interframe
// - Contention period: interframe or boundary window
// - Poll confirm immediately, or after data arrives
`default_nettype none
`include "pdpa_defines.vh"

module pdpa_core #(
  parameter CW = 16
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_sym_tick,
  input wire i_bo_boundary,
  input wire i_beacon_enabled,
  input wire i_in_cap,
  input wire i_cap_room_ok,
  input wire i_auto_request,
  input wire i_scan_active,
  input wire i_dst_is_pan_coord,
  input wire [CW-1:0] i_sifs_syms,
  input wire [CW-1:0] i_unit_bo_syms,
  input wire [CW-1:0] i_resp_wait_syms,
  input wire [CW-1:0] i_max_wait_syms,
  input wire [`PDPA_SEQ_W-1:0] i_dsn,
  input wire i_bcn_valid,
  input wire i_bcn_addr_pending,
  input wire i_poll_req,
  input wire [`PDPA_SEC_LVL_W-1:0] i_poll_sec_level,
  input wire [`PDPA_KEY_MODE_W-1:0] i_poll_key_mode,
  input wire [`PDPA_KEY_SRC_W-1:0] i_poll_key_src,
  input wire [`PDPA_KEY_IDX_W-1:0] i_poll_key_idx,
  input wire [`PDPA_SEC_LVL_W-1:0] i_auto_sec_level,
  input wire [`PDPA_KEY_MODE_W-1:0] i_auto_key_mode,
  input wire [`PDPA_KEY_SRC_W-1:0] i_auto_key_src,
  input wire [`PDPA_KEY_IDX_W-1:0] i_auto_key_idx,
  input wire i_cmd_ack_rx,
  input wire i_rx_done,
  input wire [2:0] i_rx_type,
  input wire i_rx_ar,
  input wire i_rx_fp,
  input wire i_rx_bcast,
  input wire i_rx_empty,
  input wire i_rx_is_dreq,
  input wire i_rx_from_coord,
  input wire [`PDPA_SEQ_W-1:0] i_rx_seq,
  input wire i_q_decided,
  input wire i_q_has_data,
  input wire i_q_data_ar,
  input wire i_tx_done,
  input wire i_ack_rx,
  input wire i_ack_fp,
  input wire i_ack_timeout,
  output reg o_tx_start,
  output reg [1:0] o_tx_kind,
  output reg o_tx_ar,
  output reg o_tx_fp,
  output reg [`PDPA_SEQ_W-1:0] o_tx_seq,
  output reg o_tx_csma,
  output reg o_tx_omit_dst,
  output reg [`PDPA_SEC_LVL_W-1:0] o_sec_level,
  output reg [`PDPA_KEY_MODE_W-1:0] o_sec_key_mode,
  output reg [`PDPA_KEY_SRC_W-1:0] o_sec_key_src,
  output reg [`PDPA_KEY_IDX_W-1:0] o_sec_key_idx,
  output reg o_tx_ok,
  output reg o_rx_enable,
  output reg o_poll_confirm,
  output reg [1:0] o_poll_status,
  output reg o_data_ind,
  output reg o_no_data,
  output reg o_more_pending
);

  // ==========================================================
  // State
  reg [1:0] rq_state;
  reg [2:0] ap_state;
  reg pend;
  reg pend_poll;
  reg cur_poll;
  reg ind_due;
  reg ack_is_dreq;
  reg [`PDPA_SEQ_W-1:0] ack_seq;
  reg ack_fp;

  wire [CW:0] turn_sum = i_sifs_syms + i_unit_bo_syms;
  wire [CW-1:0] turn_len = turn_sum[CW-1:0];
  wire [CW-1:0] tc_count;
  wire tc_run;
  wire tc_expire;
  wire tw_expire;
  wire tr_expire;

  // ==========================================================
  // Decodes
  wire cap_mode = i_beacon_enabled & i_in_cap;
  wire rx_acked_type = (i_rx_type == `PDPA_FT_DATA) | (i_rx_type == `PDPA_FT_CMD);
  // Broadcasts and frames without the request flag get no reply
  wire ack_ok = i_rx_done & i_rx_ar & ~i_rx_bcast & rx_acked_type & (ap_state == `PDPA_AP_IDLE);
  wire in_window = tc_run & (tc_count <= i_unit_bo_syms);
  wire ack_go = (ap_state == `PDPA_AP_TURN) &
    (cap_mode ? ((i_bo_boundary & in_window) | tc_expire)
              : ((tc_run & (tc_count == i_unit_bo_syms)) | tc_expire));
  // Direct send only inside a contention period with room for frame, spacing and reply
  wire fu_direct = (ap_state == `PDPA_AP_FTURN) & cap_mode & i_cap_room_ok & i_bo_boundary & in_window;
  wire fu_csma = (ap_state == `PDPA_AP_FTURN) & tc_expire & ~fu_direct;
  wire fu_go = fu_direct | fu_csma;
  wire tc_load = ack_ok | ((ap_state == `PDPA_AP_SEND) & i_tx_done & ack_is_dreq);
  wire bcn_trig = i_bcn_valid & i_bcn_addr_pending & i_auto_request & ~i_scan_active;
  // Requests in a beacon network wait for the contention period
  wire dreq_go = (rq_state == `PDPA_RQ_IDLE) & pend & (ap_state == `PDPA_AP_IDLE) & ~ack_ok &
    (i_in_cap | ~i_beacon_enabled);
  wire data_in = (rq_state == `PDPA_RQ_WAIT) & i_rx_done & i_rx_from_coord & (i_rx_type == `PDPA_FT_DATA);

  // ==========================================================
  // Symbol counters
  // Turnaround shared by acknowledgment and follow-up; responder does one at a time
  pdpa_symcnt #(.W(CW)) u_turn (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_load(tc_load),
    .i_value(turn_len),
    .i_clear(ack_go | fu_go),
    .i_tick(i_sym_tick),
    .o_count(tc_count),
    .o_run(tc_run),
    .o_expire(tc_expire)
  );

  pdpa_symcnt #(.W(CW)) u_wait (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_load((rq_state == `PDPA_RQ_TX) & i_ack_rx & i_ack_fp),
    .i_value(i_max_wait_syms),
    .i_clear(data_in),
    .i_tick(i_sym_tick),
    .o_count(),
    .o_run(),
    .o_expire(tw_expire)
  );

  pdpa_symcnt #(.W(CW)) u_resp (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_load(i_cmd_ack_rx),
    .i_value(i_resp_wait_syms),
    .i_clear(1'b0),
    .i_tick(i_sym_tick),
    .o_count(),
    .o_run(),
    .o_expire(tr_expire)
  );

  // ==========================================================
  // Responder: acknowledgment then pending-data follow-up
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ap_state <= `PDPA_AP_IDLE;
      ack_is_dreq <= `PDPA_CNT_RST;
      ack_seq <= {`PDPA_SEQ_W{1'b0}};
      ack_fp <= `PDPA_CNT_RST;
    end
    else
    begin
      case (ap_state)
        `PDPA_AP_IDLE:
        begin
          if (ack_ok)
          begin
            ack_seq <= i_rx_seq;
            ack_is_dreq <= i_rx_is_dreq & (i_rx_type == `PDPA_FT_CMD);
            // Unknown queue state at reply time must promise data
            ack_fp <= i_rx_is_dreq & (i_q_decided ? i_q_has_data : 1'b1);
            ap_state <= `PDPA_AP_TURN;
          end
        end
        `PDPA_AP_TURN:
        begin
          if (ack_go)
          begin
            ap_state <= `PDPA_AP_SEND;
          end
        end
        `PDPA_AP_SEND:
        begin
          if (i_tx_done)
          begin
            ap_state <= ack_is_dreq ? `PDPA_AP_FTURN : `PDPA_AP_IDLE;
          end
        end
        `PDPA_AP_FTURN:
        begin
          if (fu_go)
          begin
            ap_state <= `PDPA_AP_FSEND;
          end
        end
        `PDPA_AP_FSEND:
        begin
          // A lost reply is not retried; only a new request restarts delivery
          if (i_tx_done)
          begin
            ap_state <= `PDPA_AP_IDLE;
          end
        end
        default:
        begin
          ap_state <= `PDPA_AP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Requester
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rq_state <= `PDPA_RQ_IDLE;
      pend <= `PDPA_CNT_RST;
      pend_poll <= `PDPA_CNT_RST;
      cur_poll <= `PDPA_CNT_RST;
      ind_due <= `PDPA_CNT_RST;
      o_rx_enable <= 1'b0;
      o_poll_confirm <= 1'b0;
      o_poll_status <= `PDPA_ST_DATA;
      o_data_ind <= 1'b0;
      o_no_data <= 1'b0;
      o_more_pending <= 1'b0;
    end
    else
    begin
      o_poll_confirm <= 1'b0;
      o_data_ind <= ind_due;
      ind_due <= 1'b0;
      o_no_data <= 1'b0;
      // New triggers are latched even while a request is in flight
      if (i_poll_req)
      begin
        pend <= 1'b1;
        pend_poll <= 1'b1;
      end
      else if (bcn_trig | tr_expire)
      begin
        pend <= 1'b1;
        // A poll leaving now must not lend its keys to this automatic request
        if (dreq_go)
        begin
          pend_poll <= 1'b0;
        end
      end
      else if (dreq_go)
      begin
        pend <= 1'b0;
        pend_poll <= 1'b0;
      end
      case (rq_state)
        `PDPA_RQ_IDLE:
        begin
          if (dreq_go)
          begin
            cur_poll <= pend_poll;
            rq_state <= `PDPA_RQ_TX;
          end
        end
        `PDPA_RQ_TX:
        begin
          if (i_ack_rx)
          begin
            if (i_ack_fp)
            begin
              o_rx_enable <= 1'b1;
              rq_state <= `PDPA_RQ_WAIT;
            end
            else
            begin
              o_no_data <= 1'b1;
              o_more_pending <= 1'b0;
              o_poll_confirm <= cur_poll;
              o_poll_status <= `PDPA_ST_NODATA;
              rq_state <= `PDPA_RQ_IDLE;
            end
          end
          else if (i_ack_timeout)
          begin
            o_poll_confirm <= cur_poll;
            o_poll_status <= `PDPA_ST_NOACK;
            rq_state <= `PDPA_RQ_IDLE;
          end
        end
        `PDPA_RQ_WAIT:
        begin
          if (data_in)
          begin
            o_rx_enable <= 1'b0;
            o_more_pending <= i_rx_fp;
            o_poll_confirm <= cur_poll;
            if (i_rx_empty)
            begin
              o_no_data <= 1'b1;
              o_poll_status <= `PDPA_ST_NODATA;
            end
            else
            begin
              o_poll_status <= `PDPA_ST_DATA;
              ind_due <= 1'b1;
            end
            rq_state <= `PDPA_RQ_IDLE;
          end
          else if (tw_expire)
          begin
            o_rx_enable <= 1'b0;
            o_no_data <= 1'b1;
            o_poll_confirm <= cur_poll;
            o_poll_status <= `PDPA_ST_NODATA;
            rq_state <= `PDPA_RQ_IDLE;
          end
        end
        default:
        begin
          rq_state <= `PDPA_RQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Transmit request
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_tx_start <= 1'b0;
      o_tx_kind <= `PDPA_K_ACK;
      o_tx_ar <= 1'b0;
      o_tx_fp <= 1'b0;
      o_tx_seq <= {`PDPA_SEQ_W{1'b0}};
      o_tx_csma <= 1'b0;
      o_tx_omit_dst <= 1'b0;
      o_sec_level <= {`PDPA_SEC_LVL_W{1'b0}};
      o_sec_key_mode <= {`PDPA_KEY_MODE_W{1'b0}};
      o_sec_key_src <= {`PDPA_KEY_SRC_W{1'b0}};
      o_sec_key_idx <= {`PDPA_KEY_IDX_W{1'b0}};
      o_tx_ok <= 1'b0;
    end
    else
    begin
      o_tx_start <= ack_go | fu_go | dreq_go;
      // Frames sent without the request flag count as delivered at end of air time
      o_tx_ok <= (i_tx_done & ~o_tx_ar) | ((rq_state == `PDPA_RQ_TX) & i_ack_rx);
      if (ack_go)
      begin
        o_tx_kind <= `PDPA_K_ACK;
        o_tx_ar <= 1'b0;
        o_tx_fp <= ack_fp;
        o_tx_seq <= ack_seq;
        o_tx_csma <= 1'b0;
        o_tx_omit_dst <= 1'b0;
      end
      else if (fu_go)
      begin
        o_tx_kind <= i_q_has_data ? `PDPA_K_DATA : `PDPA_K_EMPTY;
        o_tx_ar <= i_q_has_data & i_q_data_ar;
        o_tx_fp <= 1'b0;
        o_tx_seq <= i_dsn;
        o_tx_csma <= fu_csma;
        o_tx_omit_dst <= 1'b0;
      end
      else if (dreq_go)
      begin
        o_tx_kind <= `PDPA_K_DREQ;
        o_tx_ar <= 1'b1;
        o_tx_fp <= 1'b0;
        o_tx_seq <= i_dsn;
        o_tx_csma <= 1'b1;
        o_tx_omit_dst <= i_dst_is_pan_coord;
        o_sec_level <= pend_poll ? i_poll_sec_level : i_auto_sec_level;
        o_sec_key_mode <= pend_poll ? i_poll_key_mode : i_auto_key_mode;
        o_sec_key_src <= pend_poll ? i_poll_key_src : i_auto_key_src;
        o_sec_key_idx <= pend_poll ? i_poll_key_idx : i_auto_key_idx;
      end
    end
  end

endmodule // pdpa_core

`default_nettype wire

// *** hdl/pdpa_defines.vh ***
// Shared constants for the pending-data poll and acknowledgment logic.
// Assumes inclusion by bare name from the core design file of this block.
`ifndef PDPA_DEFINES_VH
`define PDPA_DEFINES_VH

// ==========================================================
// Frame types as reported by the receive filter
`define PDPA_FT_BEACON 3'h0
`define PDPA_FT_DATA 3'h1
`define PDPA_FT_ACK 3'h2
`define PDPA_FT_CMD 3'h3

// ==========================================================
// Kinds of frame this block asks the transmitter to send
`define PDPA_K_ACK 2'h0
`define PDPA_K_DREQ 2'h1
`define PDPA_K_DATA 2'h2
`define PDPA_K_EMPTY 2'h3

// ==========================================================
// Poll confirm status codes
`define PDPA_ST_DATA 2'h0
`define PDPA_ST_NODATA 2'h1
`define PDPA_ST_NOACK 2'h2

// ==========================================================
// Requester states
`define PDPA_RQ_IDLE 2'h0
`define PDPA_RQ_TX 2'h1
`define PDPA_RQ_WAIT 2'h2

// ==========================================================
// Responder (acknowledgment and follow-up) states
`define PDPA_AP_IDLE 3'h0
`define PDPA_AP_TURN 3'h1
`define PDPA_AP_SEND 3'h2
`define PDPA_AP_FTURN 3'h3
`define PDPA_AP_FSEND 3'h4

// ==========================================================
// Field widths and reset values
`define PDPA_SEQ_W 8
`define PDPA_SEC_LVL_W 3
`define PDPA_KEY_MODE_W 2
`define PDPA_KEY_SRC_W 64
`define PDPA_KEY_IDX_W 8
`define PDPA_CNT_RST 1'b0

`endif

// *** hdl/pdpa_symcnt.v ***
// Down-counter of symbol periods used for every timed window of the block.
// Assumes i_tick is a one-cycle strobe, one per symbol period.
`default_nettype none

module pdpa_symcnt #(
  parameter W = 16
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_load,
  input wire [W-1:0] i_value,
  input wire i_clear,
  input wire i_tick,
  output reg [W-1:0] o_count,
  output reg o_run,
  output reg o_expire
);

  // ==========================================================
  // Counter
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_count <= {W{1'b0}};
      o_run <= 1'b0;
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      if (i_clear)
      begin
        o_run <= 1'b0;
      end
      else if (i_load)
      begin
        o_count <= i_value;
        o_run <= 1'b1;
      end
      else if (o_run && i_tick)
      begin
        // A zero load still waits one tick so expiry is never missed
        if (o_count <= {{(W-1){1'b0}}, 1'b1})
        begin
          o_count <= {W{1'b0}};
          o_run <= 1'b0;
          o_expire <= 1'b1;
        end
        else
        begin
          o_count <= o_count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // pdpa_symcnt

`default_nettype wire

// *** tb/pdpa_core_props.sv ***
// Port-level checks of the poll and acknowledgment block.
// Assumes one clock domain; bound to every pdpa_core instance.
`default_nettype none
module pdpa_core_props #(
  parameter CW = 16
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_sym_tick,
  input wire i_beacon_enabled,
  input wire i_in_cap,
  input wire [CW-1:0] i_sifs_syms,
  input wire [CW-1:0] i_unit_bo_syms,
  input wire [CW-1:0] i_max_wait_syms,
  input wire i_rx_done,
  input wire [2:0] i_rx_type,
  input wire i_rx_ar,
  input wire i_rx_bcast,
  input wire i_rx_from_coord,
  input wire [7:0] i_rx_seq,
  input wire i_ack_rx,
  input wire i_ack_fp,
  input wire o_tx_start,
  input wire [1:0] o_tx_kind,
  input wire o_tx_ar,
  input wire o_tx_csma,
  input wire [7:0] o_tx_seq,
  input wire o_rx_enable,
  input wire o_no_data
);
  // ===
  // Helper state
  logic [7:0] lseq;
  logic [CW:0] tk;
  logic [CW:0] win;
  wire ackst = o_tx_start && o_tx_kind == 2'h0;
  wire rxar = i_rx_done && i_rx_ar;
  wire want = rxar && !i_rx_bcast && i_rx_type[0];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Ticks are counted from the cycle after the last symbol, so a tick
  // coinciding with the end of frame is not charged to the turnaround
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lseq <= '0;
      tk <= '0;
      win <= '0;
    end
    else
    begin
      if (rxar)
      begin
        lseq <= i_rx_seq;
        tk <= '0;
      end
      else
        tk <= tk + (CW+1)'(i_sym_tick);
      win <= o_rx_enable ? win + (CW+1)'(i_sym_tick) : '0;
    end
  end
  // ===
  // Assertions
  chk_ack_clean: assert property (ackst |-> !o_tx_ar && !o_tx_csma) else $error("ack flags");
  chk_ack_seq: assert property (ackst |-> o_tx_seq == lseq) else $error("ack seq");
  chk_ack_due: assert property (want |-> ##[1:200] ackst) else $error("no ack");
  chk_unreq_quiet: assert property (i_rx_done && (i_rx_bcast || !i_rx_ar) |=> !ackst [*8]) else $error("ack");
  chk_turn_exact:
    assert property (ackst && !(i_beacon_enabled && i_in_cap) |-> tk >= i_sifs_syms && tk <= i_sifs_syms + 1)
    else $error("turnaround");
  chk_turn_cap:
    assert property (ackst && i_beacon_enabled && i_in_cap |-> tk >= i_sifs_syms
      && tk <= i_sifs_syms + i_unit_bo_syms + 1) else $error("cap turnaround");
  chk_fp_listen: assert property (i_ack_rx && i_ack_fp |=> o_rx_enable) else $error("rx off");
  chk_fp_clear: assert property (i_ack_rx && !i_ack_fp |=> o_no_data && !o_rx_enable) else $error("fp0");
  chk_wait_cap: assert property (o_rx_enable |-> win <= i_max_wait_syms + 1) else $error("rx window");
  chk_rx_close:
    assert property (o_rx_enable && i_rx_done && i_rx_type == 3'h1 && i_rx_from_coord |=> !o_rx_enable)
    else $error("rx stays on");
  cov_ack: cover property (ackst);
  cov_wait: cover property (i_ack_rx && i_ack_fp);
  cov_empty: cover property (o_tx_start && o_tx_kind == 2'h3);
endmodule // pdpa_core_props
bind pdpa_core pdpa_core_props #(.CW(CW)) u_props (.*);
`default_nettype wire

// *** tb/pdpa_peer.sv ***
// Coordinator-side peer: ends every frame, answers data requests.
// Assumes the block's start pulse and kind; drives at falling edges.
`default_nettype none
module pdpa_peer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [1:0] kind,
  output logic tx_done,
  output logic ack_rx,
  output logic ack_fp,
  output logic ack_to,
  output logic rx_done,
  output logic [16:0] rx_f
);
  timeunit 1ns;
  timeprecision 1ps;
  int txc = 0, ac = 0, dc = 0;
  bit noack, pend, dat, go;
  logic [16:0] dfr = '0, fr = '0;
  initial {tx_done, ack_rx, ack_fp, ack_to, rx_done, rx_f} = '0;
  task automatic frame(input logic [16:0] v);
    @(posedge clk);
    fr <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Idle fields carry junk so a stale frame is never mistaken for a new one
  always @(negedge clk)
  begin
    {tx_done, ack_rx, ack_to, rx_done} <= '0;
    ack_fp <= ~ack_fp;
    rx_f <= 17'($urandom);
    if (txc == 1) tx_done <= 1'b1;
    if (ac == 1)
    begin
      ack_rx <= !noack;
      ack_to <= noack;
      ack_fp <= pend;
    end
    if (dc == 1 || go)
    begin
      rx_done <= 1'b1;
      rx_f <= go ? fr : dfr;
    end
    txc <= (start && rst_b) ? 4 : (txc ? txc - 1 : 0);
    ac <= (start && kind == 2'h1) ? 6 : (ac ? ac - 1 : 0);
    dc <= (ac == 1 && pend && dat && !noack) ? 10 : (dc ? dc - 1 : 0);
  end
endmodule // pdpa_peer
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for pdpa_core against a coordinator peer.
// Assumes a 100 MHz clock, symbol tick every 2 cycles, backoff every 4.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  bit i_sys_clk, i_rst_b, i_sym_tick, i_bo_boundary, i_beacon_enabled, i_in_cap, i_cap_room_ok, i_auto_request;
  bit i_scan_active, i_dst_is_pan_coord, i_bcn_valid, i_bcn_addr_pending, i_poll_req, i_cmd_ack_rx;
  bit i_q_decided, i_q_has_data, i_q_data_ar;
  bit [15:0] i_sifs_syms, i_unit_bo_syms, i_resp_wait_syms, i_max_wait_syms;
  bit [7:0] i_dsn, i_poll_key_idx, i_auto_key_idx;
  bit [2:0] i_poll_sec_level, i_auto_sec_level;
  bit [1:0] i_poll_key_mode, i_auto_key_mode;
  bit [63:0] i_poll_key_src, i_auto_key_src;
  logic i_rx_done, i_rx_ar, i_rx_fp, i_rx_bcast, i_rx_empty, i_rx_is_dreq, i_rx_from_coord;
  logic i_tx_done, i_ack_rx, i_ack_fp, i_ack_timeout;
  logic [2:0] i_rx_type;
  logic [7:0] i_rx_seq, o_tx_seq, o_sec_key_idx, s8;
  logic o_tx_start, o_tx_ar, o_tx_fp, o_tx_csma, o_tx_omit_dst, o_tx_ok, o_rx_enable;
  logic o_poll_confirm, o_data_ind, o_no_data, o_more_pending, sa, sc, so, more, dar;
  logic [1:0] o_tx_kind, o_poll_status, o_sec_key_mode, st, sk, e;
  logic [2:0] o_sec_level;
  logic [63:0] o_sec_key_src;
  logic [16:0] rx_f;
  logic [85:0] dq;
  logic [8:0] af;
  logic [3:0] c;
  logic [3:0] pc [5] = '{4'h0, 4'hc, 4'he, 4'h8, 4'h1};
  logic [3:0] qc [4] = '{4'h7, 4'h9, 4'he, 4'hd};
  int ns, nc, nd, ni, nk, cyc, mismatches, checked;
  assign {i_rx_type, i_rx_ar, i_rx_fp, i_rx_bcast, i_rx_empty, i_rx_is_dreq, i_rx_from_coord, i_rx_seq} = rx_f;
  pdpa_core #(.CW(16)) DUT (.*);
  pdpa_peer peer (.clk(i_sys_clk), .rst_b(i_rst_b), .start(o_tx_start), .kind(o_tx_kind), .tx_done(i_tx_done),
    .ack_rx(i_ack_rx), .ack_fp(i_ack_fp), .ack_to(i_ack_timeout), .rx_done(i_rx_done), .rx_f(rx_f));
  // ===
  // Expectations
  function automatic logic [1:0] est(input logic [3:0] v);
    if (v[0]) return 2'h2;
    return (v[3] && v[2] && !v[1]) ? 2'h0 : 2'h1;
  endfunction
  function automatic logic afp(input logic dec, has);
    return dec ? has : 1'b1;
  endfunction
  function automatic logic [16:0] fm(input logic [2:0] t, input logic ar, fp, bc, em, rq, co, input logic [7:0] s);
    return {t, ar, fp, bc, em, rq, co, s};
  endfunction
  // ===
  // Drivers and monitor
  task automatic pulse(ref bit s);
    @(negedge i_sys_clk) s = 1'b1;
    @(negedge i_sys_clk) s = 1'b0;
  endtask
  task automatic settle;
    repeat (120) @(negedge i_sys_clk);
  endtask
  task automatic clr;
    {ns, nc, nd, ni, nk} = '0;
    dq = '0;
  endtask
  task automatic stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(negedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    i_sym_tick <= cyc[0];
    i_bo_boundary <= cyc[1:0] == 2'h3;
    if (o_tx_start === 1'b1)
    begin
      ns++;
      if (o_tx_kind === 2'h0) af = {o_tx_fp, o_tx_seq};
      else {sk, sa, sc, so} = {o_tx_kind, o_tx_ar, o_tx_csma, o_tx_omit_dst};
      if (o_tx_kind === 2'h1) dq = {o_tx_ar, o_tx_seq, o_sec_level, o_sec_key_mode, o_sec_key_idx, o_sec_key_src};
    end
    if (o_poll_confirm === 1'b1) st = o_poll_status;
    nc += (o_poll_confirm === 1'b1);
    nd += (o_no_data === 1'b1);
    ni += (o_data_ind === 1'b1);
    nk += (o_tx_ok === 1'b1);
  end
  initial
  begin
    #100us;
    mismatches++;
    stop_test;
  end
  // ===
  // Scenarios
  initial
  begin
    void'($urandom(70));
    {i_sifs_syms, i_unit_bo_syms, i_resp_wait_syms, i_max_wait_syms} = {16'h3, 16'h2, 16'h5, 16'h14};
    {i_beacon_enabled, i_in_cap, i_cap_room_ok, i_bcn_addr_pending} = 4'hf;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst_b = 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      c = pc[k % 5];
      {peer.pend, peer.dat, peer.noack} = {c[3], c[2], c[0]};
      more = 1'($urandom);
      dar = !c[1] && 1'($urandom);
      peer.dfr = fm(3'h1, dar, more, 1'b0, c[1], 1'b0, 1'b1, 8'($urandom));
      {i_dsn, i_poll_sec_level, i_poll_key_mode, i_poll_key_idx, i_poll_key_src} = 85'({$urandom, $urandom, $urandom});
      e = est(c);
      clr;
      pulse(i_poll_req);
      settle;
      `CHK(dq, {1'b1, i_dsn, i_poll_sec_level, i_poll_key_mode, i_poll_key_idx, i_poll_key_src})
      `CHK(nc, 1)
      `CHK(st, e)
      `CHK(nd, e == 2'h1)
      `CHK(ni, e == 2'h0)
      `CHK(ns, 1 + (e == 2'h0 && dar))
      if (e == 2'h0) `CHK(o_more_pending, more)
    end
    {peer.pend, peer.noack, i_auto_request} = 3'h1;
    for (int s = 0; s < 2; s++)
    begin
      i_scan_active = s[0];
      {i_auto_sec_level, i_auto_key_mode, i_auto_key_idx, i_auto_key_src} = 77'({$urandom, $urandom, $urandom});
      clr;
      pulse(i_bcn_valid);
      settle;
      `CHK(ns, 1 - s)
      `CHK(nc, 0)
      if (s == 0) `CHK(dq, {1'b1, i_dsn, i_auto_sec_level, i_auto_key_mode, i_auto_key_idx, i_auto_key_src})
    end
    {i_auto_request, i_scan_active, i_dst_is_pan_coord} = 3'h1;
    clr;
    pulse(i_cmd_ack_rx);
    repeat (6) @(negedge i_sys_clk);
    `CHK(ns, 0)
    settle;
    `CHK(ns, 1)
    `CHK(so, 1'b1)
    for (int k = 0; k < 4; k++)
    begin
      {i_q_decided, i_q_has_data, i_q_data_ar, i_cap_room_ok} = qc[k];
      s8 = 8'($urandom);
      clr;
      peer.frame(fm(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, s8));
      settle;
      `CHK(af, {afp(qc[k][3], qc[k][2]), s8})
      `CHK(ns, 2)
      `CHK(sk, qc[k][2] ? 2'h2 : 2'h3)
      `CHK(sa, qc[k][2] & qc[k][1])
      `CHK(sc, !qc[k][0])
      `CHK(nk, 2 - (qc[k][2] & qc[k][1]))
    end
    for (int k = 0; k < 8; k++)
    begin
      {i_beacon_enabled, i_in_cap} = k[1:0];
      c = (k < 4) ? 4'h1 : 4'($urandom);
      s8 = 8'($urandom);
      clr;
      peer.frame(fm(3'h1, c[0], 1'b0, c[1], 1'b0, 1'b0, 1'b0, s8));
      settle;
      `CHK(ns, c[0] & !c[1])
      if (ns == 1) `CHK(af, {1'b0, s8})
    end
    stop_test;
  end
endmodule // tb
`default_nettype wire
